// ==== src/psa_cfg.svh ====
// Purpose: constants for the bus-side arbiter and sideband block
// Assumes: one system clock at 25 MHz
// Notes:   counts are in system clock cycles
`ifndef PSA_CFG_SVH
`define PSA_CFG_SVH
`define PSA_NUM_MASTERS     4
`define PSA_REQ_IDLE_MIN    2
`define PSA_CLK_DIV_FAST    1
`define PSA_CLK_DIV_SLOW    2
`define PSA_STRAP_SETTLE    4
`define PSA_IRQ_SYNC_STAGES 2
`define PSA_ERR_SRC_COUNT   9
`define PSA_ERR_ADDR_PAR    0
`define PSA_ERR_PW_PAR      1
`define PSA_ERR_PW_MABORT   2
`define PSA_ERR_PW_TABORT   3
`define PSA_ERR_PW_DISCARD  4
`define PSA_ERR_DW_DISCARD  5
`define PSA_ERR_DR_DISCARD  6
`define PSA_ERR_DT_TIMEOUT  7
`define PSA_ERR_UPSTREAM    8
`define PSA_SELF_ID         3'h4
`endif

// ==== src/psa_pkg.sv ====
// Purpose: shared types for the bus-side arbiter and sideband block
// Assumes: constants header included alongside
// Notes:   types only
package psa_pkg;
   typedef enum logic {PSA_PORT_EEPROM, PSA_PORT_SMBUS} psa_port_e;
   typedef enum logic [1:0] {PSA_ARB_IDLE, PSA_ARB_GRANT, PSA_ARB_BUSY} psa_arb_e;
   typedef logic [3:0] psa_lines_t;
endpackage : psa_pkg

// ==== src/psa_if.sv ====
// Purpose: pins between the bridge bus side and an external master group
// Assumes: open-drain error line resolved here from enables
// Notes:   no clocking block
`timescale 1ns/1ns
interface psa_if;
   import psa_pkg::*;
   logic [3:0] req_n;
   logic [3:0] gnt_n;
   logic [3:0] clk_out;
   logic [3:0] clk_oe;
   logic       clk0_fb;
   logic       bus_reset_n;
   logic [3:0] irq_n;
   logic       fast_bus_strap;
   logic       serial_port_select_strap;
   logic       reserved_mode_strap;
   logic       dev_serr_oe;
   logic       host_serr_oe;
   logic       system_error_n;
   logic       frame_n;
   logic       irdy_n;
   // wired-and of open-drain drivers
   assign system_error_n = ~(dev_serr_oe | host_serr_oe);
   modport dev  (input req_n, clk0_fb, irq_n, fast_bus_strap, serial_port_select_strap,
                 reserved_mode_strap, system_error_n, frame_n, irdy_n,
                 output gnt_n, clk_out, clk_oe, bus_reset_n, dev_serr_oe);
   modport host (input gnt_n, clk_out, clk_oe, bus_reset_n, system_error_n,
                 output req_n, clk0_fb, irq_n, fast_bus_strap, serial_port_select_strap,
                 reserved_mode_strap, host_serr_oe, frame_n, irdy_n);
endinterface : psa_if

// ==== src/psa_host.sv ====
// Purpose: external masters, straps and interrupt sources around the bridge
// Assumes: user side asks for the bus per master; one clock
// Notes:   keeps request gaps and strap levels
`timescale 1ns/1ns
`include "psa_cfg.svh"
module psa_host (
   input  wire logic                 i_sys_clk,
   input  wire logic                 i_arst_n,
   psa_if.host                       bus,
   input  wire logic [3:0]           i_want,
   input  wire logic [3:0]           i_done,
   input  wire logic [3:0]           i_irq,
   input  wire logic                 i_serr,
   input  wire logic                 i_fast,
   input  wire logic                 i_smbus,
   input  wire logic                 i_clkrun_strap,
   output logic      [3:0]           o_owned,
   output logic                      o_serr_seen
);
   import psa_pkg::*;
   logic [3:0] req_reg;
   logic [3:0] own_reg;
   logic [1:0] gap_reg [4];
   logic       frame_reg;

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         req_reg <= 4'h0;
         own_reg <= 4'h0;
         for (int i = 0; i < 4; i++) gap_reg[i] <= 2'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (req_reg[i]) begin
               if (!bus.gnt_n[i]) own_reg[i] <= 1'b1;
               // a waiting master may withdraw, an owner leaves on done
               if ((own_reg[i] && i_done[i]) || (!own_reg[i] && !i_want[i])) begin
                  req_reg[i] <= 1'b0;
                  own_reg[i] <= 1'b0;
                  gap_reg[i] <= 2'h0;
               end
            end else if (gap_reg[i] < 2'(`PSA_REQ_IDLE_MIN)) begin
               gap_reg[i] <= gap_reg[i] + 2'h1;
            end else if (i_want[i]) begin
               req_reg[i] <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) frame_reg <= 1'b0;
      else frame_reg <= |own_reg;
   end

   assign bus.frame_n = ~(frame_reg & bus.bus_reset_n);
   assign bus.irdy_n  = ~(frame_reg & bus.bus_reset_n);
   // strap high holds requests 2 and 3 low for clock-run
   assign bus.req_n   = ~req_reg & {~i_clkrun_strap, ~i_clkrun_strap, 2'b11};
   assign bus.clk0_fb = bus.clk_out[1];
   assign bus.irq_n   = ~i_irq;
   assign bus.fast_bus_strap = i_fast;
   assign bus.serial_port_select_strap = i_smbus;
   assign bus.reserved_mode_strap = 1'b0;
   assign bus.host_serr_oe = i_serr;

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_owned     <= 4'h0;
         o_serr_seen <= 1'b0;
      end else begin
         o_owned     <= own_reg;
         o_serr_seen <= ~bus.system_error_n;
      end
   end
endmodule : psa_host

// ==== src/psa_dev.sv ====
// Purpose: bus-side arbiter, clocks, straps and error line of the bridge
// Assumes: bus clock outputs derived by enable divider from i_sys_clk
// Notes:   straps caught after reset release
`timescale 1ns/1ns
`include "psa_cfg.svh"
module psa_dev #(
   parameter int NUM_MASTERS = `PSA_NUM_MASTERS
) (
   input  wire logic                 i_sys_clk,
   input  wire logic                 i_arst_n,
   psa_if.dev                        bus,
   input  wire logic                 i_ext_arbiter,
   input  wire logic                 i_feedback_mode,
   input  wire logic                 i_serr_enable,
   input  wire logic [8:0]           i_err_events,
   input  wire logic                 i_self_request,
   input  wire logic                 i_bus_reset_req,
   input  wire logic [2:0]           i_general_output,
   output logic      [2:0]           o_general_input,
   output logic                      o_self_granted,
   output logic                      o_park_drive,
   output logic      [3:0]           o_irq_level,
   output logic                      o_fast_bus,
   output psa_pkg::psa_port_e        o_serial_port,
   output logic                      o_clock_run_mode,
   output logic                      o_strap_fault
);
   import psa_pkg::*;

   function automatic logic [2:0] next_owner(input logic [2:0] last, input logic [4:0] req);
      logic [2:0] cand;
      next_owner = `PSA_SELF_ID;
      for (int k = 5; k >= 1; k--) begin
         cand = 3'((32'(last) + k) % 5);
         if (req[cand]) next_owner = cand;
      end
   endfunction : next_owner

   psa_arb_e   arb_reg;
   logic [2:0] owner_reg;
   logic [3:0] gnt_reg;
   logic       ext_req_reg;
   logic [2:0] gpo_reg;
   logic [2:0] gpi_reg;
   logic       serr_reg;
   logic [3:0] irq_s1_reg;
   logic [3:0] irq_s2_reg;
   logic [1:0] div_reg;
   logic [3:0] clk_reg;
   logic [2:0] settle_reg;
   logic       strap_done_reg;
   logic       clkrun_reg;
   logic       fast_reg;
   logic       port_reg;
   logic       reset_out_reg;
   logic       park_reg;
   logic       self_gnt_reg;
   logic [4:0] req_vec;
   logic       bus_idle;

   assign req_vec  = {i_self_request, ~bus.req_n};
   assign bus_idle = bus.frame_n & bus.irdy_n;

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         arb_reg   <= PSA_ARB_IDLE;
         owner_reg <= `PSA_SELF_ID;
      end else begin
         case (arb_reg)
            PSA_ARB_IDLE: begin
               if (!i_ext_arbiter && bus_idle) begin
                  owner_reg <= next_owner(owner_reg, req_vec);
                  arb_reg   <= PSA_ARB_GRANT;
               end
            end
            PSA_ARB_GRANT: begin
               if (!bus_idle) arb_reg <= PSA_ARB_BUSY;
               else if (owner_reg == `PSA_SELF_ID || !req_vec[owner_reg]) arb_reg <= PSA_ARB_IDLE;
            end
            PSA_ARB_BUSY: begin
               // only re-arbitrate once the transaction ends
               if (bus_idle) arb_reg <= PSA_ARB_IDLE;
            end
            default: arb_reg <= PSA_ARB_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) gnt_reg <= 4'h0;
      else if (i_ext_arbiter || arb_reg == PSA_ARB_IDLE) gnt_reg <= 4'h0;
      else if (owner_reg < 3'(NUM_MASTERS)) gnt_reg <= 4'h1 << owner_reg[1:0];
      else gnt_reg <= 4'h0;
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         park_reg     <= 1'b0;
         self_gnt_reg <= 1'b0;
      end else begin
         park_reg     <= !i_ext_arbiter && gnt_reg == 4'h0 && bus_idle && reset_out_reg;
         self_gnt_reg <= i_ext_arbiter ? !bus.req_n[0] : owner_reg == `PSA_SELF_ID;
      end
   end

   // request out on grant line zero
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ext_req_reg <= 1'b0;
         gpo_reg     <= 3'h0;
         gpi_reg     <= 3'h0;
      end else begin
         ext_req_reg <= i_self_request;
         gpo_reg     <= i_general_output;
         gpi_reg     <= i_ext_arbiter ? ~bus.req_n[3:1] : 3'h0;
      end
   end

   assign bus.gnt_n = i_ext_arbiter ? ~{gpo_reg, ext_req_reg} : ~gnt_reg;

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) serr_reg <= 1'b0;
      else serr_reg <= i_serr_enable && |i_err_events;
   end

   assign bus.dev_serr_oe = serr_reg;

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         irq_s1_reg <= 4'h0;
         irq_s2_reg <= 4'h0;
      end else begin
         irq_s1_reg <= ~bus.irq_n;
         irq_s2_reg <= irq_s1_reg;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         settle_reg     <= 3'h0;
         strap_done_reg <= 1'b0;
         clkrun_reg     <= 1'b0;
         fast_reg       <= 1'b0;
         port_reg       <= 1'b0;
      end else if (!strap_done_reg) begin
         settle_reg <= settle_reg + 3'h1;
         if (settle_reg == 3'(`PSA_STRAP_SETTLE)) begin
            strap_done_reg <= 1'b1;
            clkrun_reg     <= !bus.req_n[2] && !bus.req_n[3];
            fast_reg       <= bus.fast_bus_strap;
            port_reg       <= bus.serial_port_select_strap;
         end
      end else if (bus.req_n[2] || bus.req_n[3]) begin
         // strap must stay low; drop the mode if released
         clkrun_reg <= 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         div_reg <= 2'h0;
         clk_reg <= 4'h0;
      end else begin
         div_reg <= (div_reg >= 2'(fast_reg ? `PSA_CLK_DIV_FAST : `PSA_CLK_DIV_SLOW) - 2'h1)
                    ? 2'h0 : div_reg + 2'h1;
         if (div_reg == 2'h0) clk_reg <= ~clk_reg;
      end
   end

   assign bus.clk_out = {clkrun_reg ? 1'b0 : clk_reg[3],
                         clkrun_reg ? 1'b0 : clk_reg[2], clk_reg[1:0]};
   assign bus.clk_oe  = {1'b1, 1'b1, 1'b1, !i_feedback_mode};

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) reset_out_reg <= 1'b0;
      else reset_out_reg <= !i_bus_reset_req;
   end
   assign bus.bus_reset_n = reset_out_reg;

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_general_input  <= 3'h0;
         o_self_granted   <= 1'b0;
         o_park_drive     <= 1'b0;
         o_irq_level      <= 4'h0;
         o_fast_bus       <= 1'b0;
         o_serial_port    <= PSA_PORT_EEPROM;
         o_clock_run_mode <= 1'b0;
         o_strap_fault    <= 1'b0;
      end else begin
         o_general_input  <= gpi_reg;
         o_self_granted   <= self_gnt_reg;
         o_park_drive     <= park_reg;
         o_irq_level      <= irq_s2_reg;
         o_fast_bus       <= fast_reg;
         o_serial_port    <= port_reg ? PSA_PORT_SMBUS : PSA_PORT_EEPROM;
         o_clock_run_mode <= clkrun_reg;
         o_strap_fault    <= bus.reserved_mode_strap;
      end
   end
endmodule : psa_dev

// ==== dv/psa_checker.sv ====
// Purpose: concurrent checks on the pins between the two ends
// Assumes: one clock; arbiter mode and straps change only under reset
// Notes:   divider judged only once the straps have settled
`timescale 1ns/1ns
module psa_checker (
   input  wire logic       i_sys_clk,
   input  wire logic       i_arst_n,
   input  wire logic [3:0] gnt_n,
   input  wire logic [3:0] clk_out,
   input  wire logic [3:0] clk_oe,
   input  wire logic       fast_bus_strap,
   input  wire logic       dev_serr_oe,
   input  wire logic       system_error_n,
   input  wire logic       frame_n,
   input  wire logic       i_ext_arbiter,
   input  wire logic       i_serr_enable,
   input  wire logic [8:0] i_err_events,
   input  wire logic [2:0] i_general_output
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_arst_n);
   logic [3:0] up_reg;
   // strap capture takes five edges, so wait longer
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) up_reg <= 4'h0;
      else if (up_reg != 4'hF) up_reg <= up_reg + 4'h1;
   end
   property p_serr_raise;
      i_serr_enable && |i_err_events |=> dev_serr_oe;
   endproperty
   a_serr_raise: assert property (p_serr_raise) else $error("error line not driven");
   property p_serr_quiet;
      !i_serr_enable || i_err_events == 9'h0 |=> !dev_serr_oe;
   endproperty
   a_serr_quiet: assert property (p_serr_quiet) else $error("error line driven idle");
   property p_serr_wire;
      dev_serr_oe |-> !system_error_n;
   endproperty
   a_serr_wire: assert property (p_serr_wire) else $error("error line not low");
   property p_one_grant;
      !i_ext_arbiter |-> $countones(~gnt_n) <= 1;
   endproperty
   a_one_grant: assert property (p_one_grant) else $error("several grants");
   property p_grant_between;
      !i_ext_arbiter && !frame_n |-> ((~gnt_n) & $past(gnt_n)) == 4'h0;
   endproperty
   a_grant_between: assert property (p_grant_between) else $error("grant in transfer");
   property p_ext_gpo;
      i_ext_arbiter |=> gnt_n[3:1] == ~$past(i_general_output);
   endproperty
   a_ext_gpo: assert property (p_ext_gpo) else $error("general output wrong");
   property p_clk_fast;
      up_reg == 4'hF && clk_oe[1] && fast_bus_strap && $changed(clk_out[1])
         |=> $changed(clk_out[1]);
   endproperty
   a_clk_fast: assert property (p_clk_fast) else $error("fast clock wrong");
   property p_clk_slow;
      up_reg == 4'hF && clk_oe[1] && !fast_bus_strap && $changed(clk_out[1])
         |=> $stable(clk_out[1]) ##1 $changed(clk_out[1]);
   endproperty
   a_clk_slow: assert property (p_clk_slow) else $error("slow clock wrong");
endmodule : psa_checker

// ==== dv/tb_top.sv ====
// Purpose: self-checking bench joining both ends of the block
// Assumes: mode and straps change only under reset
// Notes:   self competes only alone, its request path is shorter
`timescale 1ns/1ns
module tb_top;
   import psa_pkg::*;
   logic i_sys_clk = 1'b0, i_arst_n = 1'b0, i_ext_arbiter = 1'b0, i_feedback_mode = 1'b0;
   logic i_serr_enable = 1'b0, i_self_request = 1'b0, i_bus_reset_req = 1'b0;
   logic i_serr = 1'b0, i_fast = 1'b1, i_smbus = 1'b1, i_clkrun_strap = 1'b0;
   logic [8:0] i_err_events = 9'h0;
   logic [2:0] i_general_output = 3'h0, o_general_input, last, exp;
   logic [3:0] i_want = 4'h0, i_done = 4'h0, i_irq = 4'h0, o_irq_level, o_owned;
   logic o_self_granted, o_park_drive, o_fast_bus, o_clock_run_mode, o_strap_fault;
   logic o_serr_seen;
   psa_port_e o_serial_port;
   logic [7:0] seed = 8'h15;
   logic [4:0] m;
   int errors = 0, checked = 0, n;
   psa_if i_psa_if ();
   always #20 i_sys_clk = ~i_sys_clk;
   psa_dev i_psa_dev (.i_sys_clk, .i_arst_n, .bus(i_psa_if), .i_ext_arbiter, .i_feedback_mode,
      .i_serr_enable, .i_err_events, .i_self_request, .i_bus_reset_req, .i_general_output,
      .o_general_input, .o_self_granted, .o_park_drive, .o_irq_level, .o_fast_bus,
      .o_serial_port, .o_clock_run_mode, .o_strap_fault);
   psa_host i_psa_host (.i_sys_clk, .i_arst_n, .bus(i_psa_if), .i_want, .i_done, .i_irq,
      .i_serr, .i_fast, .i_smbus, .i_clkrun_strap, .o_owned, .o_serr_seen);
   psa_checker i_psa_checker (.i_sys_clk, .i_arst_n, .gnt_n(i_psa_if.gnt_n),
      .clk_out(i_psa_if.clk_out), .clk_oe(i_psa_if.clk_oe),
      .fast_bus_strap(i_psa_if.fast_bus_strap), .dev_serr_oe(i_psa_if.dev_serr_oe),
      .system_error_n(i_psa_if.system_error_n), .frame_n(i_psa_if.frame_n),
      .i_ext_arbiter, .i_serr_enable, .i_err_events, .i_general_output);
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   // next requester after the last owner, self is id 4
   function automatic logic [2:0] next_own(input logic [2:0] l, input logic [4:0] r);
      logic [2:0] c;
      c = l;
      for (int i = 0; i < 5; i++) begin
         c = (c == 3'h4) ? 3'h0 : c + 3'h1;
         if (r[c]) return c;
      end
      return c;
   endfunction : next_own
   task automatic look(input int k);
      repeat (k) @(posedge i_sys_clk);
      #1;
   endtask : look
   task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic test_done;
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : test_done
   // bounded wait for the expected owner, then compare once it has settled
   task automatic grab(input logic [2:0] e);
      n = 0;
      while (((e == 3'h4) ? o_self_granted !== 1'b1 : i_psa_if.gnt_n !== ~(4'h1 << e[1:0]))
             && n < 40) begin
         look(1);
         n++;
      end
      if (n == 40) begin
         errors++;
         test_done();
      end
      look(1);
      chk("gnt", {5'h0, (e == 3'h4) ? 4'hF : ~(4'h1 << e[1:0])}, {5'h0, i_psa_if.gnt_n});
      chk("self", {8'h0, e == 3'h4}, {8'h0, o_self_granted});
   endtask : grab
   task automatic rst;
      @(posedge i_sys_clk);
      i_arst_n <= 1'b0;
      repeat (6) @(posedge i_sys_clk);
      i_arst_n <= 1'b1;
      look(8);
   endtask : rst
   initial begin
      rst();
      chk("fast", 9'h1, 9'(o_fast_bus));
      chk("port", 9'(PSA_PORT_SMBUS), 9'(o_serial_port));
      chk("fault", 9'h0, 9'(o_strap_fault));
      chk("park", 9'h1, 9'(o_park_drive));
      chk("brst", 9'h1, 9'(i_psa_if.bus_reset_n));
      // the arbiter parks on self between rounds
      last = 3'h4;
      for (int r = 0; r < 14; r++) begin
         seed = lfsr(seed);
         m = (seed[3:0] != 4'h0) ? {1'b0, seed[3:0]} : 5'h10;
         exp = next_own(last, m);
         @(posedge i_sys_clk);
         i_want <= m[3:0];
         i_self_request <= m[4];
         grab(exp);
         look(6);
         i_done <= m[3:0];
         // the others keep asking, so the next grant follows the owner
         i_want <= m[3:0] & ~(4'h1 << exp[1:0]);
         i_self_request <= 1'b0;
         look(1);
         i_done <= 4'h0;
         if (i_want != 4'h0) begin
            exp = next_own(exp, {1'b0, i_want});
            grab(exp);
            look(6);
            i_done <= i_want;
            i_want <= 4'h0;
            look(1);
            i_done <= 4'h0;
         end
         look(6);
      end
      for (int b = 0; b < 18; b++) begin
         seed = lfsr(seed);
         @(posedge i_sys_clk);
         i_serr_enable <= (b < 9) | seed[0];
         i_err_events <= 9'h1 << (b % 9);
         look(2);
         chk("serr", {8'h0, ~i_serr_enable}, 9'(i_psa_if.system_error_n));
      end
      seed = lfsr(seed);
      @(posedge i_sys_clk);
      i_err_events <= 9'h0;
      i_serr <= 1'b1;
      i_irq <= seed[3:0];
      i_feedback_mode <= 1'b1;
      i_bus_reset_req <= 1'b1;
      look(4);
      chk("wire", 9'h0, 9'(i_psa_if.system_error_n));
      chk("oe", 9'h0, 9'(i_psa_if.dev_serr_oe));
      chk("seen", 9'h1, 9'(o_serr_seen));
      chk("irq", 9'(seed[3:0]), 9'(o_irq_level));
      chk("fb", 9'h0, 9'(i_psa_if.clk_oe[0]));
      chk("brst", 9'h0, 9'(i_psa_if.bus_reset_n));
      i_ext_arbiter <= 1'b1;
      i_fast <= 1'b0;
      i_smbus <= 1'b0;
      i_clkrun_strap <= 1'b1;
      i_serr <= 1'b0;
      i_feedback_mode <= 1'b0;
      i_bus_reset_req <= 1'b0;
      rst();
      chk("fast", 9'h0, 9'(o_fast_bus));
      chk("port", 9'(PSA_PORT_EEPROM), 9'(o_serial_port));
      chk("run", 9'h1, 9'(o_clock_run_mode));
      chk("clk32", 9'h0, 9'(i_psa_if.clk_out[3:2]));
      seed = lfsr(seed);
      @(posedge i_sys_clk);
      i_general_output <= seed[2:0];
      i_want <= {2'h0, seed[3], 1'b1};
      i_self_request <= 1'b1;
      look(5);
      chk("gpi", 9'({2'h3, seed[3]}), 9'(o_general_input));
      chk("gpo", {6'h0, ~seed[2:0]}, 9'(i_psa_if.gnt_n[3:1]));
      chk("req", 9'h0, 9'(i_psa_if.gnt_n[0]));
      chk("own", 9'h1, 9'(o_self_granted));
      test_done();
   end
endmodule : tb_top
